// *** core/uipc_defs.vh ***
// register map, field positions and reset values of the serial port control block
`ifndef UIPC_DEFS_VH
`define UIPC_DEFS_VH

// byte addresses on the apb bus
`define UIPC_ADDR_MODE_ONE   8'h00
`define UIPC_ADDR_MODE_TWO   8'h04
`define UIPC_ADDR_FLAGS      8'h08
`define UIPC_ADDR_COMMAND    8'h0C
`define UIPC_ADDR_CLKSEL     8'h10
`define UIPC_ADDR_CHANGE     8'h14
`define UIPC_ADDR_AUX        8'h18
`define UIPC_ADDR_MASK       8'h1C
`define UIPC_ADDR_BAUD_HI    8'h20
`define UIPC_ADDR_BAUD_LO    8'h24
`define UIPC_ADDR_VECTOR     8'h28
`define UIPC_ADDR_PINS       8'h2C
`define UIPC_ADDR_RTS_SET    8'h30
`define UIPC_ADDR_RTS_CLR    8'h34
`define UIPC_ADDR_STATUS     8'h38

// flag and mask bit positions
`define UIPC_BIT_TX_HOLDING_EMPTY       0
`define UIPC_BIT_RXF         1
`define UIPC_BIT_BREAK       2
`define UIPC_BIT_COS         7
`define UIPC_FLAG_MASK       8'h87

// field positions
`define UIPC_M1_RX_FLOW_REQUEST        7
`define UIPC_M1_RF           6
`define UIPC_M1_ERR          5
`define UIPC_M2_TX_FLOW_REQUEST        5
`define UIPC_M2_TX_FLOW_GATE        4
`define UIPC_CHG_COS         4
`define UIPC_CMD_BRK_CLR     8'h50
`define UIPC_CMD_FIELD_LSB   4

// reset values and limits
`define UIPC_VECTOR_RESET    8'h0F
`define UIPC_BAUD_MIN        16'h0002
`define UIPC_LOOPBACK_MODE   2'h2

`endif

// *** core/uipc_sync.v ***
// two flip-flop synchroniser for a single level
`timescale 1ns/1ps
module uipc_sync (
	// clock and reset
	input  wire mclk,
	input  wire rst,
	// level in and out
	input  wire async_in,
	output wire sync_out
);
	reg meta_q;
	reg sync_q;

	// first stage read only by second stage
	always @(posedge mclk) begin
		if (rst) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
	assign sync_out = sync_q;
endmodule

// *** core/uipc_ctrl.v ***
// serial port control: interrupt flags, mask, vector, baud preload, cts and rts
`timescale 1ns/1ps
`include "uipc_defs.vh"
module uipc_ctrl #(
	parameter PORT_NUM = 0
) (
	// clock and reset
	input  wire        mclk,
	input  wire        rst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// status from transmitter and receiver
	input  wire        tx_holding_empty,
	input  wire        rx_ready_flag,
	input  wire        rx_full_flag,
	input  wire        break_detect,
	// serial pins
	input  wire        cts_n_pin,
	output wire        rts_n_pin,
	input  wire        tx_serial,
	input  wire        rx_pin,
	output wire        rx_to_receiver,
	// settings to the shifters
	output wire [15:0] baud_preload,
	output wire        baud_too_low,
	output wire [7:0]  mode_one,
	output wire [7:0]  mode_two,
	output wire [7:0]  clock_select,
	output reg  [3:0]  command_pulse,
	output wire        loopback_on,
	output wire        tx_gate_cts,
	// interrupt
	output reg         irq,
	output wire [7:0]  irq_vector,
	input  wire        autovector_sel,
	output wire        irq_use_autovector
);
	localparam HAS_FLOW = (PORT_NUM != 2);

	reg [7:0] mask_q;
	reg [7:0] baud_hi_q;
	reg [7:0] baud_lo_q;
	reg [7:0] vector_q;
	reg [7:0] mode_one_q;
	reg [7:0] mode_two_q;
	reg [7:0] clksel_q;
	reg       aux_iec_q;
	reg       rts_q;
	reg       cos_chg_q;
	reg       cos_flag_q;
	reg       brk_flag_q;
	reg       brk_last_q;
	reg       cts_last_q;
	reg       cts_primed_q;
	wire      cts_sync;
	wire      wr_en;
	wire      rd_en;
	wire      cts_level;
	wire      cts_edge;
	wire      brk_edge;
	wire      brk_clear;
	wire      rx_mirror;
	wire [7:0] flags;

	// cts pin reaches logic only through two flops
	uipc_sync u_cts_sync (
		.mclk     (mclk),
		.rst      (rst),
		.async_in (cts_n_pin),
		.sync_out (cts_sync)
	);

	// apb: zero wait states, no error answer
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// cts input level; port two has no cts so it reads high
	// omit cts on port two
	assign cts_level = HAS_FLOW ? cts_sync : 1'b1;
	assign cts_edge  = cts_primed_q & (cts_level != cts_last_q);
	assign brk_edge  = break_detect != brk_last_q;
	assign brk_clear = wr_en & (paddr == `UIPC_ADDR_COMMAND) &&
		(pwdata[7:0] == `UIPC_CMD_BRK_CLR);

	// ready or full by mode bit
	assign rx_mirror = mode_one_q[`UIPC_M1_RF] ? rx_full_flag : rx_ready_flag;

	assign flags = {cos_flag_q, 4'h0, brk_flag_q, rx_mirror, tx_holding_empty};

	// control registers written by software
	always @(posedge mclk) begin
		if (rst) begin
			mask_q     <= 8'h00;
			baud_hi_q  <= 8'h00;
			baud_lo_q  <= 8'h00;
			vector_q   <= `UIPC_VECTOR_RESET;
			mode_one_q <= 8'h00;
			mode_two_q <= 8'h00;
			clksel_q   <= 8'h00;
			aux_iec_q  <= 1'b0;
		end else if (wr_en) begin
			case (paddr)
				`UIPC_ADDR_MASK:    mask_q     <= pwdata[7:0] & `UIPC_FLAG_MASK;
				`UIPC_ADDR_BAUD_HI: baud_hi_q  <= pwdata[7:0];
				`UIPC_ADDR_BAUD_LO: baud_lo_q  <= pwdata[7:0];
				`UIPC_ADDR_VECTOR:  vector_q   <= pwdata[7:0];
				`UIPC_ADDR_MODE_ONE: mode_one_q <= pwdata[7:0];
				`UIPC_ADDR_MODE_TWO: mode_two_q <= pwdata[7:0];
				`UIPC_ADDR_CLKSEL:  clksel_q   <= pwdata[7:0];
				`UIPC_ADDR_AUX:     aux_iec_q  <= pwdata[0];
				default: ;
			endcase
		end
	end

	// command field handed on as a one-cycle pulse
	always @(posedge mclk) begin
		if (rst) begin
			command_pulse <= 4'h0;
		end else if (wr_en && paddr == `UIPC_ADDR_COMMAND) begin
			command_pulse <= pwdata[`UIPC_CMD_FIELD_LSB +: 4];
		end else begin
			command_pulse <= 4'h0;
		end
	end

	// rts latch; clear checked first but set and clear are separate addresses
	always @(posedge mclk) begin
		if (rst) begin
			rts_q <= 1'b0;
		end else if (HAS_FLOW) begin
			if (wr_en && paddr == `UIPC_ADDR_RTS_CLR && pwdata[0]) begin
				rts_q <= 1'b0;
			end else if (wr_en && paddr == `UIPC_ADDR_RTS_SET && pwdata[0]) begin
				rts_q <= 1'b1;
			end
		end
	end

	assign rts_n_pin = ~rts_q;

	// change tracking; the first sample after reset primes, as if from power up
	always @(posedge mclk) begin
		if (rst) begin
			cts_last_q   <= 1'b1;
			cts_primed_q <= 1'b0;
			cos_chg_q    <= 1'b0;
			cos_flag_q   <= 1'b0;
			// track the break level so a break held over reset makes no false edge
			brk_last_q   <= break_detect;
			brk_flag_q   <= 1'b0;
		end else begin
			cts_last_q   <= cts_level;
			cts_primed_q <= 1'b1;
			brk_last_q   <= break_detect;
			// change bit: set wins over the read-clear
			if (cts_edge) begin
				cos_chg_q <= 1'b1;
			end else if (rd_en && paddr == `UIPC_ADDR_CHANGE) begin
				cos_chg_q <= 1'b0;
			end
			if (cts_edge && aux_iec_q) begin
				cos_flag_q <= 1'b1;
			end else if (rd_en && paddr == `UIPC_ADDR_CHANGE) begin
				cos_flag_q <= 1'b0;
			end
			if (brk_edge) begin
				brk_flag_q <= 1'b1;
			end else if (brk_clear) begin
				brk_flag_q <= 1'b0;
			end
		end
	end

	// reset clears flags (above); registered level irq
	always @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags & mask_q);
		end
	end

	// register read mux; write-only and unmapped read as zero
	always @* begin
		prdata = 32'h0000_0000;
		case (paddr)
			`UIPC_ADDR_MODE_ONE: prdata[7:0] = mode_one_q;
			`UIPC_ADDR_MODE_TWO: prdata[7:0] = mode_two_q;
			`UIPC_ADDR_FLAGS:    prdata[7:0] = flags;
			`UIPC_ADDR_CHANGE:   prdata[7:0] = {3'h0, cos_chg_q, 3'h0, cts_level};
			`UIPC_ADDR_AUX:      prdata[7:0] = {7'h00, aux_iec_q};
			`UIPC_ADDR_MASK:     prdata[7:0] = mask_q;
			`UIPC_ADDR_VECTOR:   prdata[7:0] = vector_q;
			`UIPC_ADDR_PINS:     prdata[7:0] = {7'h00, cts_level};
			`UIPC_ADDR_STATUS:   prdata[7:0] = {6'h00, baud_too_low, rts_q};
			default:             prdata = 32'h0000_0000;
		endcase
	end

	assign baud_preload = {baud_hi_q, baud_lo_q};
	// flag a preload software left too small
	assign baud_too_low = baud_preload < `UIPC_BAUD_MIN;

	assign irq_vector         = vector_q;
	assign irq_use_autovector = autovector_sel;

	assign loopback_on    = mode_two_q[7:6] == `UIPC_LOOPBACK_MODE;
	assign rx_to_receiver = loopback_on ? tx_serial : rx_pin;

	// transmit gating by cts when enabled
	assign tx_gate_cts = mode_two_q[`UIPC_M2_TX_FLOW_GATE] & cts_level;

	assign mode_one     = mode_one_q;
	assign mode_two     = mode_two_q;
	assign clock_select = clksel_q;
endmodule

// *** verif/uipc_peer.sv ***
// serial peer model driving the flow-control and receive lines
`timescale 1ns/1ps
module uipc_peer (
	// clock and wish of the bench
	input  wire logic mclk,
	input  wire logic cts_req,
	// lines towards the port
	output logic      cts_n_pin,
	output logic      rx_pin
);
	// steps on the clock so the port never sees a runt edge
	initial cts_n_pin = 1'b1;
	always @(posedge mclk) cts_n_pin <= cts_req;
	// no frames sent, line rests at its idle mark
	assign rx_pin = 1'b1;
endmodule

// *** verif/uipc_ctrl_assertions.sv ***
// concurrent checks on the serial port control ports
`timescale 1ns/1ps
module uipc_chk (
	// clock, reset and apb
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// status, pins and interrupt
	input wire logic        tx_holding_empty,
	input wire logic        cts_n_pin,
	input wire logic        rts_n_pin,
	input wire logic        irq,
	input wire logic [7:0]  irq_vector
);
	logic [7:0] mask_q;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// shadow mask, the block does not export its own
	always @(posedge mclk)
		if (rst) mask_q <= 8'h00;
		else if (psel && penable && pwrite && paddr == 8'h1C) mask_q <= pwdata[7:0];
	// access phase of one transfer
	sequence s_wr(a);
		psel && penable && pwrite && paddr == a;
	endsequence
	sequence s_rd(a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	chk_irq_enabled:
	assert property (mask_q[0] && tx_holding_empty |=> irq) else $error("irq not raised");
	chk_irq_masked:
	assert property (mask_q == 8'h00 |=> !irq) else $error("irq with mask clear");
	chk_rts_set:
	assert property (s_wr(8'h30) ##0 pwdata[0] |=> !rts_n_pin) else $error("rts not set");
	chk_rts_clear:
	assert property (s_wr(8'h34) ##0 pwdata[0] |=> rts_n_pin) else $error("rts not cleared");
	chk_rts_hold:
	assert property (!(psel && penable && pwrite && paddr[7:3] == 5'h06) |=> $stable(rts_n_pin))
		else $error("rts moved");
	chk_vec_reset:
	assert property ($fell(rst) |-> irq_vector == 8'h0F) else $error("vector reset");
	chk_vec_read:
	assert property (s_rd(8'h28) |-> prdata == {24'h0, irq_vector}) else $error("vector read");
	chk_baud_hidden:
	assert property (s_rd(8'h20) or s_rd(8'h24) |-> prdata == 32'h0) else $error("divisor read");
	chk_pin_read:
	assert property (s_rd(8'h2C) |-> prdata == {31'h0, $past(cts_n_pin, 2)}) else $error("pin read");
endmodule
bind uipc_ctrl uipc_chk u_chk (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.tx_holding_empty, .cts_n_pin, .rts_n_pin, .irq, .irq_vector);

// *** verif/tb_top.sv ***
// self-checking bench for the serial port control block
`timescale 1ns/1ps
module tb_top;
	logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        tx_holding_empty = 1'b0, rx_ready_flag = 1'b0, rx_full_flag = 1'b0;
	logic        break_detect = 1'b0, tx_serial = 1'b1, autovector_sel = 1'b0, cts_req = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, r;
	wire  [31:0] prdata;
	wire  [15:0] baud_preload;
	wire         pready, rts_n_pin, cts_n_pin, rx_pin, rx_to_receiver, loopback_on, irq, irq_use_av;
	int          failures = 0, n_compared = 0;
	// 10 MHz system clock
	always #50 mclk = ~mclk;
	uipc_ctrl uut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr(), .tx_holding_empty, .rx_ready_flag, .rx_full_flag, .break_detect, .cts_n_pin,
		.rts_n_pin, .tx_serial, .rx_pin, .rx_to_receiver, .baud_preload, .baud_too_low(),
		.mode_one(), .mode_two(), .clock_select(), .command_pulse(), .loopback_on,
		.tx_gate_cts(), .irq, .irq_vector(), .autovector_sel, .irq_use_autovector(irq_use_av));
	uipc_peer peer (.mclk, .cts_req, .cts_n_pin, .rx_pin);
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// one apb transfer held until pready is seen high at a rising edge, then an idle edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(n, r, e);
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task print_verdict;
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// watchdog, the sequence needs well under a thousand cycles
	initial begin
		hold(3000);
		failures++;
		print_verdict;
	end
	// main sequence
	initial begin
		hold(8);
		rst <= 1'b0;
		rd("vector", 8'h28, 32'h0F);
		// init order kept, divisor not below two
		wr(8'h20, 32'h12);
		wr(8'h24, 32'h34);
		chk("preload", baud_preload, 32'h1234);
		rd("div_hi", 8'h20, 32'h0);
		rd("div_lo", 8'h24, 32'h0);
		wr(8'h28, 32'hA5);
		rd("vector", 8'h28, 32'hA5);
		wr(8'h18, 32'h1);
		wr(8'h10, 32'hDD);
		wr(8'h00, 32'h40);
		wr(8'h04, 32'h00);
		// status shows through a closed mask, then the mask opens
		tx_holding_empty <= 1'b1;
		rx_full_flag <= 1'b1;
		rd("flags", 8'h08, 32'h03);
		chk("irq", irq, 32'h0);
		wr(8'h1C, 32'h87);
		rd("mask", 8'h1C, 32'h87);
		chk("irq", irq, 32'h1);
		tx_holding_empty <= 1'b0;
		rx_full_flag <= 1'b0;
		hold(3);
		chk("irq", irq, 32'h0);
		// receive flag follows the notify select
		rx_ready_flag <= 1'b1;
		rd("flags", 8'h08, 32'h00);
		wr(8'h00, 32'h00);
		rd("flags", 8'h08, 32'h02);
		rx_ready_flag <= 1'b0;
		// break start and end each raise the flag
		break_detect <= 1'b1;
		rd("flags", 8'h08, 32'h04);
		wr(8'h0C, 32'h50);
		rd("flags", 8'h08, 32'h00);
		break_detect <= 1'b0;
		rd("flags", 8'h08, 32'h04);
		wr(8'h0C, 32'h50);
		// cts change with its enable on, then off
		cts_req <= 1'b0;
		hold(4);
		rd("flags", 8'h08, 32'h80);
		rd("pins", 8'h2C, 32'h0);
		rd("change", 8'h14, 32'h10);
		rd("flags", 8'h08, 32'h00);
		wr(8'h18, 32'h0);
		cts_req <= 1'b1;
		hold(4);
		rd("flags", 8'h08, 32'h00);
		rd("pins", 8'h2C, 32'h1);
		// request line through its set and clear places
		wr(8'h30, 32'h0);
		chk("rts_n", rts_n_pin, 32'h1);
		wr(8'h30, 32'h1);
		chk("rts_n", rts_n_pin, 32'h0);
		wr(8'h34, 32'h0);
		chk("rts_n", rts_n_pin, 32'h0);
		wr(8'h34, 32'h1);
		chk("rts_n", rts_n_pin, 32'h1);
		// loopback, autovector, unmapped place
		wr(8'h04, 32'h80);
		chk("loop", loopback_on, 32'h1);
		tx_serial <= 1'b0;
		hold(1);
		chk("rx_recv", rx_to_receiver, 32'h0);
		autovector_sel <= 1'b1;
		hold(1);
		chk("autovec", irq_use_av, 32'h1);
		rd("unmapped", 8'h3C, 32'h0);
		// module reset in mid-run with a break flag pending
		break_detect <= 1'b1;
		hold(3);
		rst <= 1'b1;
		hold(2);
		rst <= 1'b0;
		rd("flags", 8'h08, 32'h00);
		rd("vector", 8'h28, 32'h0F);
		print_verdict;
	end
endmodule
